// *** pkg/timer_defines.svh ***
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// register byte offsets
`define TMR_OFF_CTRL    8'h00
`define TMR_OFF_MODE    8'h04
`define TMR_OFF_TIMER   8'h08
`define TMR_OFF_STATUS  8'h0C
`define TMR_OFF_MASK    8'h10
`define TMR_OFF_PORT    8'h14

// control register fields
`define TMR_CTRL_START  0

// mode register fields
`define TMR_MODE_LSB    0
`define TMR_MODE_MSB    1
`define TMR_MODE_PULSE  2
`define TMR_MODE_GATE   3
`define TMR_CSEL_LSB    4
`define TMR_CSEL_MSB    5

// status and mask fields
`define TMR_STS_UF      0
`define TMR_STS_GATE    1
`define TMR_STS_OUT     2

// port register fields
`define TMR_PORT_DAT    0
`define TMR_PORT_DIR    1
`define TMR_PORT_IN     2

// prescaler taps
`define TMR_DIV8_LAST   5'h07
`define TMR_DIV32_LAST  5'h1F
`define TMR_DIV8_MASK   5'h07

// reset values
`define TMR_RST_COUNT   16'h0000
`define TMR_RST_BIT     1'b0

`endif

// *** pkg/timer_pkg.sv ***
package timer_pkg;

	// mode field of the mode register
	typedef enum logic [1:0]
	{
		MODE_TIMER   = 2'b00,
		MODE_EVENT   = 2'b01,
		MODE_ONESHOT = 2'b10,
		MODE_PWM     = 2'b11
	} timer_mode_t;

	// count source selection
	typedef enum logic [1:0]
	{
		SRC_UNDIV = 2'b00,
		SRC_DIV8  = 2'b01,
		SRC_DIV32 = 2'b10,
		SRC_RSVD  = 2'b11
	} clk_sel_t;

endpackage

// *** design/count_prescaler.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.svh"

module count_prescaler
(
	input  wire logic              ref_clk, // system clock
	input  wire logic              srst,    // sync reset, active high
	input  wire timer_pkg::clk_sel_t sel,   // selected count source
	output var  logic              tick     // one-cycle count-source pulse
);
	import timer_pkg::*;

	typedef struct packed
	{
		logic [4:0] div_cnt;
		logic       tick;
	} pre_state_t;

	pre_state_t s_r;
	pre_state_t s_nxt;

	// free-running divider; taps give the slower sources
	always_comb
	begin
		s_nxt         = s_r;
		s_nxt.div_cnt = s_r.div_cnt + 5'h01;
		case (sel)
			SRC_UNDIV: s_nxt.tick = 1'b1; // R4
			SRC_DIV8:  s_nxt.tick = ((s_r.div_cnt & `TMR_DIV8_MASK) == `TMR_DIV8_LAST); // R4
			SRC_DIV32: s_nxt.tick = (s_r.div_cnt == `TMR_DIV32_LAST); // R4
			default:   s_nxt.tick = 1'b0; // reserved code stalls the count
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign tick = s_r.tick;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	property p_div8_spacing;
		(sel == SRC_DIV8) && tick && $stable(sel) |=> !tick [*7];
	endproperty
	a_div8_spacing: assert property (p_div8_spacing) else $error("div8 tick too early"); // R4

	property p_undiv_every;
		(sel == SRC_UNDIV) && $past(sel == SRC_UNDIV) && !$past(srst) |-> tick;
	endproperty
	a_undiv_every: assert property (p_undiv_every) else $error("undivided source missed a tick"); // R4

endmodule
`default_nettype wire

// *** design/timer_channel.sv ***
// Overview of operation
// R1 - The chip holds eight independent 16-bit timers and this module is one such channel, replicated per channel.
// R2 - The channel mode comes from the two lowest bits of the mode register.
// R3 - In one-shot mode the channel stops instead of reloading when the count is zero.
// R4 - Timer mode counts one of three prescaled clocks: undivided, divide by eight or divide by thirty-two.
// R5 - In timer mode the count decrements per source tick and reloads from the reload register at underflow.
// R6 - A programmed value n gives one underflow per n plus one source ticks.
// R7 - Counting runs while the start flag is one and stops when software clears it.
// R8 - Every underflow in timer mode raises the interrupt request; the code sets the sticky status flag and raises irq only while uf_mask is set.
// R9 - Reading the timer register returns the live count.
// R10 - A timer write while stopped loads both the reload register and the count.
// R11 - A timer write while counting loads only the reload register, taken by the count at the next reload.
// R12 - With the gate option on, the external gate pin level allows or blocks counting.
// R13 - With the pulse option on, the output pin inverts at every underflow.
// R14 - Without the gate or pulse options the pins serve as plain programmable port pins.
// R15 - Mode codes are 00 timer, 01 event counter, 10 one-shot and 11 pulse-width.
// R16 - The gate pin is synchronised and counting is allowed only while the synchronised level is high.
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.svh"

module timer_channel
#(
	parameter int WIDTH  = 16, // R1
	parameter int ADDR_W = 8   // apb address width
)
(
	input  wire logic              ref_clk,                    // 10 MHz system clock
	input  wire logic              srst,                       // sync reset, active high
	input  wire logic              psel,                       // apb select
	input  wire logic              penable,                    // apb access phase
	input  wire logic              pwrite,                     // apb direction
	input  wire logic [ADDR_W-1:0] paddr,                      // apb byte address
	input  wire logic [31:0]       pwdata,                     // apb write data
	output var  logic [31:0]       prdata,                     // apb read data
	output var  logic              pready,                     // apb ready
	output var  logic              pslverr,                    // apb error, unmapped address
	input  wire logic              timer_gate_input_pin,       // gate or plain input pin
	output var  logic              timer_pulse_output_pin,     // pulse or port output level
	output var  logic              timer_pulse_output_pin_oe,  // high while the pin is driven
	output var  logic              irq                         // level interrupt request
);
	import timer_pkg::*;

	typedef struct packed
	{
		logic             start;
		timer_mode_t      mode;
		logic             pulse_en;
		logic             gate_en;
		clk_sel_t         csel;
		logic [WIDTH-1:0] count;
		logic [WIDTH-1:0] reload;
		logic             uf_sts;
		logic             uf_mask;
		logic             port_dat;
		logic             port_dir;
		logic             pulse_lvl;
		logic             g_meta;
		logic             g_sync;
		logic             g_prev;
		logic             pready;
		logic             pslverr;
		logic [31:0]      prdata;
		logic             irq;
		logic             out_pin;
		logic             out_oe;
	} chan_state_t;

	chan_state_t s_r;
	chan_state_t s_nxt;
	logic        pre_tick;
	logic        tick;
	logic        count_en;
	logic        uf;
	logic        wr;

	// address match on an aligned word
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		hit = (a == ADDR_W'(off));
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = hit(a, `TMR_OFF_CTRL) || hit(a, `TMR_OFF_MODE) || hit(a, `TMR_OFF_TIMER)
			|| hit(a, `TMR_OFF_STATUS) || hit(a, `TMR_OFF_MASK) || hit(a, `TMR_OFF_PORT);
	endfunction

	// prescaled count source
	count_prescaler count_prescaler_inst
	(
		.ref_clk (ref_clk),
		.srst    (srst),
		.sel     (s_r.csel),
		.tick    (pre_tick)
	);

	// the whole next state of the channel
	always_comb
	begin
		s_nxt         = s_r;
		s_nxt.pready  = 1'b0;
		s_nxt.pslverr = 1'b0;

		// gate pin synchroniser; the second stage gives the level, the third its previous value for edges
		s_nxt.g_meta = timer_gate_input_pin; // R16
		s_nxt.g_sync = s_r.g_meta; // R16
		s_nxt.g_prev = s_r.g_sync;

		// event mode counts rising gate-pin edges, the other modes the prescaler
		if (s_r.mode == MODE_EVENT) // R2 R15
			tick = s_r.g_sync && !s_r.g_prev;
		else
			tick = pre_tick; // R4
		count_en = s_r.start && tick && (!s_r.gate_en || s_r.g_sync || s_r.mode == MODE_EVENT); // R7 R12 R16

		// decrement and underflow; n+1 ticks per period
		uf = 1'b0;
		if (count_en)
		begin
			if (s_r.count == '0)
			begin
				uf = 1'b1; // R8
				if (s_r.mode == MODE_ONESHOT)
					s_nxt.start = 1'b0; // R3
				else
					s_nxt.count = s_r.reload; // R5 R6 R11
			end
			else
				s_nxt.count = s_r.count - 1'b1; // R5
		end
		if (uf && s_r.pulse_en)
			s_nxt.pulse_lvl = !s_r.pulse_lvl; // R13

		// apb setup cycle: answer in the next cycle, data sampled now
		if (psel && !penable && !s_r.pready)
		begin
			s_nxt.pready  = 1'b1;
			s_nxt.pslverr = !mapped(paddr);
			s_nxt.prdata  = 32'h0000_0000;
			if (hit(paddr, `TMR_OFF_CTRL))
				s_nxt.prdata[`TMR_CTRL_START] = s_r.start;
			if (hit(paddr, `TMR_OFF_MODE))
			begin
				s_nxt.prdata[`TMR_MODE_MSB:`TMR_MODE_LSB] = s_r.mode;
				s_nxt.prdata[`TMR_MODE_PULSE]             = s_r.pulse_en;
				s_nxt.prdata[`TMR_MODE_GATE]              = s_r.gate_en;
				s_nxt.prdata[`TMR_CSEL_MSB:`TMR_CSEL_LSB] = s_r.csel;
			end
			if (hit(paddr, `TMR_OFF_TIMER))
				s_nxt.prdata[WIDTH-1:0] = s_r.count; // R9
			if (hit(paddr, `TMR_OFF_STATUS))
			begin
				s_nxt.prdata[`TMR_STS_UF]   = s_r.uf_sts;
				s_nxt.prdata[`TMR_STS_GATE] = s_r.g_sync;
				s_nxt.prdata[`TMR_STS_OUT]  = s_r.out_pin;
			end
			if (hit(paddr, `TMR_OFF_MASK))
				s_nxt.prdata[`TMR_STS_UF] = s_r.uf_mask;
			if (hit(paddr, `TMR_OFF_PORT))
			begin
				s_nxt.prdata[`TMR_PORT_DAT] = s_r.port_dat; // R14
				s_nxt.prdata[`TMR_PORT_DIR] = s_r.port_dir; // R14
				s_nxt.prdata[`TMR_PORT_IN]  = s_r.g_sync; // R14
			end
		end

		// apb write takes effect on the completing edge
		wr = psel && penable && s_r.pready && pwrite && !s_r.pslverr;
		if (wr && hit(paddr, `TMR_OFF_CTRL))
			s_nxt.start = pwdata[`TMR_CTRL_START]; // R7
		if (wr && hit(paddr, `TMR_OFF_MODE))
		begin
			s_nxt.mode     = timer_mode_t'(pwdata[`TMR_MODE_MSB:`TMR_MODE_LSB]); // R2 R15
			s_nxt.pulse_en = pwdata[`TMR_MODE_PULSE];
			s_nxt.gate_en  = pwdata[`TMR_MODE_GATE];
			s_nxt.csel     = clk_sel_t'(pwdata[`TMR_CSEL_MSB:`TMR_CSEL_LSB]); // R4
		end
		if (wr && hit(paddr, `TMR_OFF_TIMER))
		begin
			s_nxt.reload = pwdata[WIDTH-1:0]; // R10 R11
			if (!s_r.start)
				s_nxt.count = pwdata[WIDTH-1:0]; // R10
		end
		if (wr && hit(paddr, `TMR_OFF_MASK))
			s_nxt.uf_mask = pwdata[`TMR_STS_UF];
		if (wr && hit(paddr, `TMR_OFF_PORT))
		begin
			s_nxt.port_dat = pwdata[`TMR_PORT_DAT]; // R14
			s_nxt.port_dir = pwdata[`TMR_PORT_DIR]; // R14
		end

		// sticky underflow flag; a new underflow beats a clear
		if (wr && hit(paddr, `TMR_OFF_STATUS) && pwdata[`TMR_STS_UF])
			s_nxt.uf_sts = 1'b0;
		if (uf)
			s_nxt.uf_sts = 1'b1; // R8

		// outputs from next state so the pins track the flops without lag
		s_nxt.irq     = s_nxt.uf_sts && s_nxt.uf_mask; // R8
		s_nxt.out_pin = s_nxt.pulse_en ? s_nxt.pulse_lvl : s_nxt.port_dat; // R13 R14
		s_nxt.out_oe  = s_nxt.pulse_en || s_nxt.port_dir; // R14
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			s_r        <= '0;
			s_r.mode   <= MODE_TIMER;
			s_r.csel   <= SRC_UNDIV;
			s_r.count  <= `TMR_RST_COUNT;
			s_r.reload <= `TMR_RST_COUNT;
			s_r.start  <= `TMR_RST_BIT;
		end
		else
			s_r <= s_nxt;
	end

	assign prdata                    = s_r.prdata;
	assign pready                    = s_r.pready;
	assign pslverr                   = s_r.pslverr;
	assign irq                       = s_r.irq;
	assign timer_pulse_output_pin    = s_r.out_pin;
	assign timer_pulse_output_pin_oe = s_r.out_oe;

	// checks on the channel behaviour
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	logic timer_wr;
	assign timer_wr = psel && penable && s_r.pready && pwrite && hit(paddr, `TMR_OFF_TIMER);

	property p_reload;
		count_en && s_r.count == '0 && s_r.mode != MODE_ONESHOT && !timer_wr |=> s_r.count == $past(s_r.reload);
	endproperty
	a_reload: assert property (p_reload) else $error("no reload at underflow"); // R5

	property p_decrement;
		count_en && s_r.count != '0 && !timer_wr |=> s_r.count == $past(s_r.count) - 1'b1;
	endproperty
	a_decrement: assert property (p_decrement) else $error("count did not decrement"); // R6

	property p_irq;
		uf && s_r.uf_mask && !(psel && penable && pwrite && hit(paddr, `TMR_OFF_MASK)) |=> s_r.uf_sts ##0 irq;
	endproperty
	a_irq: assert property (p_irq) else $error("underflow raised no interrupt"); // R8

	property p_toggle;
		uf && s_r.pulse_en |=> s_r.pulse_lvl != $past(s_r.pulse_lvl) ##0 timer_pulse_output_pin == s_r.pulse_lvl;
	endproperty
	a_toggle: assert property (p_toggle) else $error("pulse pin did not invert"); // R13

	property p_stopped;
		!s_r.start && !timer_wr |=> $stable(s_r.count);
	endproperty
	a_stopped: assert property (p_stopped) else $error("count moved while stopped"); // R7

	property p_write_stopped;
		timer_wr && !s_r.start |=> s_r.count == $past(pwdata[WIDTH-1:0]) && s_r.reload == s_r.count;
	endproperty
	a_write_stopped: assert property (p_write_stopped) else $error("stopped write missed count"); // R10

	property p_write_running;
		timer_wr && s_r.start && !count_en |=> $stable(s_r.count) ##0 s_r.reload == $past(pwdata[WIDTH-1:0]);
	endproperty
	a_write_running: assert property (p_write_running) else $error("running write touched count"); // R11

	property p_oneshot;
		count_en && s_r.count == '0 && s_r.mode == MODE_ONESHOT && !wr |=> !s_r.start ##1 $stable(s_r.count);
	endproperty
	a_oneshot: assert property (p_oneshot) else $error("one-shot kept counting"); // R3

	property p_gate;
		s_r.gate_en && !s_r.g_sync && s_r.mode == MODE_TIMER && !timer_wr |=> $stable(s_r.count);
	endproperty
	a_gate: assert property (p_gate) else $error("count moved with gate low"); // R12

	property p_read;
		psel && !penable && !s_r.pready && hit(paddr, `TMR_OFF_TIMER) |=> pready && prdata[WIDTH-1:0] == $past(s_r.count);
	endproperty
	a_read: assert property (p_read) else $error("timer read wrong value"); // R9

	// a write landing on the reload edge must not leak into this reload
	property p_reload_on_write;
		count_en && s_r.count == '0 && s_r.mode != MODE_ONESHOT && timer_wr |=> s_r.count == $past(s_r.reload);
	endproperty
	a_reload_on_write: assert property (p_reload_on_write) else $error("write leaked into reload"); // R11

	property p_event_edge;
		s_r.mode == MODE_EVENT && s_r.start && s_r.g_sync && !s_r.g_prev && s_r.count != '0 && !timer_wr
			|=> s_r.count == $past(s_r.count) - 1'b1;
	endproperty
	a_event_edge: assert property (p_event_edge) else $error("pin edge not counted"); // R2

	property p_irq_level;
		irq |-> s_r.uf_sts && s_r.uf_mask;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq without unmasked status"); // R8

	property p_port_pin;
		!s_r.pulse_en |-> timer_pulse_output_pin == s_r.port_dat;
	endproperty
	a_port_pin: assert property (p_port_pin) else $error("port pin lost its data bit"); // R14

	property p_gate_sync;
		!$past(srst) && !$past(srst, 2) |-> s_r.g_sync == $past(timer_gate_input_pin, 2);
	endproperty
	a_gate_sync: assert property (p_gate_sync) else $error("gate sync depth wrong"); // R16

endmodule
`default_nettype wire

// *** testbench/gate_pulse_partner.sv ***
`timescale 1ns/1ps
`default_nettype none

module gate_pulse_partner
(
	input  wire logic ref_clk,    // system clock
	input  wire logic gate_level, // level the bench asks for
	output var  logic gate_pin,   // drives the channel gate pin
	input  wire logic pulse_pin,  // channel output pin
	input  wire logic pulse_oe,   // channel output enable
	output var  int   toggles,    // toggles seen while driven
	output var  int   period      // clocks between the last two toggles
);
	logic last_r = 1'b0;
	int   gap    = 0;
	int   tog_r  = 0;
	int   per_r  = 0;

	// external party holds a firm level; the channel syncs it itself
	always_comb gate_pin = gate_level;
	always_comb toggles = tog_r;
	always_comb period = per_r;

	// an undriven pin is ignored; toggles of a driven port pin still count as pulses
	always @(posedge ref_clk)
	begin
		gap <= gap + 1;
		if (pulse_oe === 1'b1 && pulse_pin !== last_r)
		begin
			tog_r <= tog_r + 1;
			per_r <= gap + 1;
			gap <= 0;
		end
		last_r <= pulse_pin;
	end
endmodule

`default_nettype wire

// *** testbench/test_timer_channel.sv ***
`timescale 1ns/1ps
`default_nettype none

module test_timer_channel;
	import timer_pkg::*;
	logic        ref_clk, srst, psel, penable, pwrite, gate_level;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, rd2;
	logic        pready, pslverr, er, gpin, opin, oe, irq;
	int          toggles, period, err_count, n_checks;
	int          cyc = 0;

	timer_channel timer_channel_inst (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer_gate_input_pin(gpin), .timer_pulse_output_pin(opin),
		.timer_pulse_output_pin_oe(oe), .irq(irq));
	gate_pulse_partner gate_pulse_partner_inst (.ref_clk(ref_clk), .gate_level(gate_level),
		.gate_pin(gpin), .pulse_pin(opin), .pulse_oe(oe), .toggles(toggles), .period(period));

	// clock, 100 ns period
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// hang guard, well above the longest scenario
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			err_count = err_count + 1;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks = n_checks + 1;
		if (got !== exp)
		begin
			err_count = err_count + 1;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// one apb transfer; answer taken at the edge that samples pready high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do
			@(posedge ref_clk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_tog(input int k);
		int t0;
		t0 = toggles;
		while (toggles < t0 + k)
			@(posedge ref_clk);
	endtask

	task automatic test_regs();
		apb(0, 8'h08, 0);
		chk(rd, 32'h0, "count after reset");
		apb(0, 8'h18, 0);
		chk({31'h0, er}, 32'h1, "unmapped error");
		chk(rd, 32'h0, "unmapped data");
		apb(1, 8'h08, 32'h0000ABCD);
		apb(0, 8'h08, 0);
		chk(rd, 32'h0000ABCD, "stopped write loads count");
		$display("test_regs done");
	endtask

	// period of the pulse pin for every prescaler source
	task automatic test_period();
		int div [3] = '{1, 8, 32};
		apb(1, 8'h10, 32'h1);
		for (int s = 0; s < 3; s++)
		begin
			apb(1, 8'h00, 0);
			apb(1, 8'h04, 32'h4 | (s << 4));
			apb(1, 8'h08, 32'h2);
			apb(1, 8'h00, 32'h1);
			wait_tog(2);
			chk(period, 3 * div[s], "underflow period");
			chk({31'h0, irq}, 32'h1, "irq on underflow");
		end
		apb(1, 8'h04, 32'h4);
		apb(1, 8'h08, 32'h5);
		wait_tog(3);
		chk(period, 32'd6, "running write at reload");
		apb(1, 8'h00, 0);
		apb(0, 8'h08, 0);
		rd2 = rd;
		repeat (5) @(posedge ref_clk);
		apb(0, 8'h08, 0);
		chk(rd, rd2, "count frozen when stopped");
		$display("test_period done");
	endtask

	task automatic test_irq();
		apb(1, 8'h10, 0);
		@(posedge ref_clk);
		chk({31'h0, irq}, 32'h0, "masked irq");
		apb(0, 8'h0C, 0);
		chk(rd & 32'h1, 32'h1, "sticky underflow");
		apb(1, 8'h0C, 32'h1);
		apb(1, 8'h10, 32'h1);
		@(posedge ref_clk);
		chk({31'h0, irq}, 32'h0, "irq after clear");
		$display("test_irq done");
	endtask

	task automatic test_gate();
		gate_level <= 1'b0;
		apb(1, 8'h04, 32'h8);
		apb(1, 8'h08, 32'h5);
		apb(1, 8'h00, 32'h1);
		repeat (20) @(posedge ref_clk);
		apb(0, 8'h08, 0);
		chk(rd, 32'h5, "gate low blocks");
		gate_level <= 1'b1;
		repeat (6) @(posedge ref_clk);
		apb(0, 8'h08, 0);
		chk({31'h0, rd < 32'h5}, 32'h1, "gate high counts");
		apb(1, 8'h00, 0);
		$display("test_gate done");
	endtask

	task automatic test_oneshot();
		apb(1, 8'h0C, 32'h1);
		apb(1, 8'h04, 32'h2);
		apb(1, 8'h08, 32'h3);
		apb(1, 8'h00, 32'h1);
		rd = 32'h1;
		for (int i = 0; i < 40 && rd[0] !== 1'b0; i++)
			apb(0, 8'h00, 0);
		chk(rd, 32'h0, "one-shot stops");
		apb(0, 8'h08, 0);
		chk(rd, 32'h0, "one-shot count zero");
		$display("test_oneshot done");
	endtask

	// event mode on pin edges, then the reserved source that never ticks
	task automatic test_event();
		gate_level <= 1'b0;
		apb(1, 8'h04, 32'h1);
		apb(1, 8'h08, 32'h3);
		apb(1, 8'h00, 32'h1);
		repeat (2)
		begin
			repeat (4) @(posedge ref_clk);
			gate_level <= 1'b1;
			repeat (4) @(posedge ref_clk);
			gate_level <= 1'b0;
		end
		repeat (4) @(posedge ref_clk);
		apb(0, 8'h08, 0);
		chk(rd, 32'h1, "event mode counts pin edges");
		apb(1, 8'h00, 0);
		apb(1, 8'h04, 32'h30);
		apb(1, 8'h08, 32'h2);
		apb(1, 8'h00, 32'h1);
		repeat (10) @(posedge ref_clk);
		apb(0, 8'h08, 0);
		chk(rd, 32'h2, "reserved source never ticks");
		apb(1, 8'h00, 0);
		$display("test_event done");
	endtask

	task automatic test_port();
		gate_level <= 1'b1;
		apb(1, 8'h04, 0);
		apb(1, 8'h14, 32'h3);
		@(posedge ref_clk);
		chk({30'h0, oe, opin}, 32'h3, "port drives pin");
		apb(0, 8'h14, 0);
		chk(rd & 32'h4, 32'h4, "port reads input pin");
		gate_level <= 1'b0;
		repeat (3) @(posedge ref_clk);
		apb(0, 8'h14, 0);
		chk(rd & 32'h4, 32'h0, "port reads low input pin");
		$display("test_port done");
	endtask

	initial
	begin
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		gate_level = 1'b1;
		err_count = 0;
		n_checks = 0;
		repeat (12) @(posedge ref_clk);
		srst <= 1'b0;
		test_regs();
		test_period();
		test_irq();
		test_gate();
		test_oneshot();
		test_event();
		test_port();
		final_report();
	end
endmodule

`default_nettype wire
